// ===== dbsb_pkg.sv
/*
 Shared constants and carrier types for the debug status and breakpoint block.
 Assumes a serial layer that delivers whole decoded commands and data words.
*/
package dbsb_pkg;
    // Command codes
    localparam logic [7:0] CMD_ENTER_DEBUG = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'hE4;
    localparam logic [7:0] CMD_WRITE_CONTROL = 8'hC4;
    localparam logic [7:0] CMD_BREAKPOINT_READ_COMMAND = 8'hE2;
    localparam logic [7:0] CMD_BREAKPOINT_WRITE_COMMAND = 8'hC2;
    // Status and control bit positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_BKPT_EN = 5;
    localparam int BIT_FTS = 4;
    localparam int BIT_WS = 2;
    localparam int BIT_WSF = 1;
    // Widths and reset values
    localparam int ADDR_W = 14;
    localparam int BKPT_W = 16;
    localparam logic [BKPT_W-1:0] BKPT_RESET = 16'h0000;
    localparam logic [7:0] STATUS_ZERO = 8'h00;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b01,
        MODE_HALT = 2'b10
    } dbsb_mode_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [15:0] data;
    } dbsb_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } dbsb_rsp_t;

    typedef struct packed {
        logic addrValid;
        logic opFetch;
        logic [ADDR_W-1:0] addr;
    } dbsb_cpu_t;

    typedef struct packed {
        logic enter;
        logic rdStatus;
        logic wrControl;
        logic rdBkpt;
        logic wrBkpt;
    } dbsb_dec_t;
endpackage

// ===== dbsb_cmd_decode.sv
/*
 Command decoder: turns one received command into a one-hot strobe set.
 Assumes cmd.valid is a one-cycle pulse from the serial layer.
*/
`timescale 1ns/1ps
module dbsb_cmd_decode (
    // Clock and reset, used by checks only
    input wire logic mclk,
    input wire logic rst_n,
    // Command in, strobes out
    input wire dbsb_pkg::dbsb_cmd_t cmd,
    output dbsb_pkg::dbsb_dec_t dec
);
    function automatic dbsb_pkg::dbsb_dec_t decode(input logic v, input logic [7:0] c);
        dbsb_pkg::dbsb_dec_t d;
        d = '0;
        if (v) begin
            d.enter = (c == dbsb_pkg::CMD_ENTER_DEBUG);
            d.rdStatus = (c == dbsb_pkg::CMD_READ_STATUS);
            d.wrControl = (c == dbsb_pkg::CMD_WRITE_CONTROL);
            d.rdBkpt = (c == dbsb_pkg::CMD_BREAKPOINT_READ_COMMAND);
            d.wrBkpt = (c == dbsb_pkg::CMD_BREAKPOINT_WRITE_COMMAND);
        end
        return d;
    endfunction

    // Other codes belong to other units and fall through as no strobe
    always_comb begin
        dec = decode(cmd.valid, cmd.code); // [RULE_18]
    end

    dec_onehot_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_18]
        cmd.valid && cmd.code == dbsb_pkg::CMD_READ_STATUS |-> dec.rdStatus && $onehot(dec))
        else $error("status read code not decoded alone");
endmodule

// ===== dbsb_bkpt_match.sv
/*
 Breakpoint comparator with force and tag handling.
 Assumes the CPU reports instruction boundaries and tagged opcodes at queue end.
*/
`timescale 1ns/1ps
module dbsb_bkpt_match #(
    parameter int AW = dbsb_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Configuration
    input wire logic breakpoint_enable_bit,
    input wire logic force_tag_select,
    input wire logic [AW-1:0] bkptAddr,
    // CPU side
    input wire dbsb_pkg::dbsb_cpu_t cpuBus,
    input wire logic instrBoundary,
    input wire logic tagExec,
    output logic tagOut,
    // Halt request toward the controller
    output logic haltHit
);
    logic match;
    logic forcePend_r;
    logic forcePend_nxt;
    logic tagOut_nxt;

    assign match = breakpoint_enable_bit && cpuBus.addrValid && (cpuBus.addr == bkptAddr); // [RULE_05]

    always_comb begin
        // Force mode: any access to the address matches, not only an opcode fetch; halt waits for the boundary
        haltHit = breakpoint_enable_bit && force_tag_select && (forcePend_r || match) && instrBoundary; // [RULE_06]
        // Tag mode: halt only if the tagged opcode really reaches execution
        if (breakpoint_enable_bit && !force_tag_select && tagExec) begin
            haltHit = 1'b1; // [RULE_07]
        end
        forcePend_nxt = breakpoint_enable_bit && force_tag_select && (forcePend_r || match) && !instrBoundary;
        tagOut_nxt = breakpoint_enable_bit && !force_tag_select && match && cpuBus.opFetch; // [RULE_07]
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            forcePend_r <= 1'b0;
            tagOut <= 1'b0;
        end else begin
            forcePend_r <= forcePend_nxt;
            tagOut <= tagOut_nxt;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence forceArm;
        breakpoint_enable_bit && force_tag_select && match && !instrBoundary;
    endsequence

    bkpt_off_a: assert property (!breakpoint_enable_bit |-> !haltHit ##1 !tagOut) // [RULE_05]
        else $error("breakpoint acted while disabled");
    force_halt_a: assert property (forceArm ##1 (breakpoint_enable_bit && force_tag_select && instrBoundary) |-> haltHit) // [RULE_06]
        else $error("forced breakpoint missed boundary");
    tag_fetch_a: assert property (breakpoint_enable_bit && !force_tag_select && match && cpuBus.opFetch |=> tagOut) // [RULE_07]
        else $error("matched opcode not tagged");
endmodule

// ===== dbsb_status_bkpt.sv
/*
 Debug status/control register, breakpoint register and halt mode control.
 Reached only by decoded serial commands; the CPU map does not see it.
 Assumes resumeReq comes from the active-mode command unit (go/trace).
*/
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - Enable clear: refuse halt, serve non-intrusive commands
// RULE_02 - Enable bit sticks at one until reset
// RULE_03 - Host sets enable when target may stop
// RULE_04 - Active flag bit 6 shows halt mode
// RULE_05 - Breakpoint enable clear disables all matching
// RULE_06 - Force select: match halts at next boundary
// RULE_07 - Tag select: tagged opcode halts at execution
// RULE_08 - Wait/stop flag bit 2 reports wait/stop origin
// RULE_09 - Enter command wakes CPU from wait/stop
// RULE_10 - Host confirms active flag before further commands
// RULE_11 - Failure flag bit 1 on wait/stop collision
// RULE_12 - Host recovers failure: enter, repeat, resume
// RULE_13 - Breakpoint register sixteen bits, fourteen implemented
// RULE_14 - Breakpoint commands accepted while program runs
// RULE_15 - Status register reached only by serial commands
// RULE_16 - Enable write ignored in halt; flags read-only
// RULE_17 - Enter command acts only when enabled
// RULE_18 - Codes E4, C4, E2, C2, 90
// RULE_19 - Unimplemented bits read zero, writes ignored
module dbsb_status_bkpt (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Serial command layer
    input wire dbsb_pkg::dbsb_cmd_t cmd,
    output dbsb_pkg::dbsb_rsp_t rsp,
    // Halt control
    input wire logic resumeReq,
    output logic haltReq,
    output logic debugActive,
    // CPU status and breakpoint taps
    input wire logic cpuWaitStop,
    input wire logic memFail,
    input wire logic instrBoundary,
    input wire logic tagExec,
    input wire dbsb_pkg::dbsb_cpu_t cpuBus,
    output logic tagOut,
    // Status flags
    output logic wsFlag,
    output logic wsfFlag
);
    dbsb_pkg::dbsb_dec_t dec;
    dbsb_pkg::dbsb_mode_t mode_r;
    dbsb_pkg::dbsb_mode_t mode_nxt;
    dbsb_pkg::dbsb_rsp_t rsp_nxt;
    logic enable_r;
    logic enable_nxt;
    logic breakpoint_enable_bit_r;
    logic breakpoint_enable_bit_nxt;
    logic fts_r;
    logic fts_nxt;
    logic [dbsb_pkg::ADDR_W-1:0] bkpt_r;
    logic [dbsb_pkg::ADDR_W-1:0] bkpt_nxt;
    logic [dbsb_pkg::ADDR_W-1:0] wrAddr;
    logic wsHalt_r;
    logic wsHalt_nxt;
    logic wsf_r;
    logic wsf_nxt;
    logic haltHit;
    logic [7:0] statusByte;

    dbsb_cmd_decode u_dec (
        .mclk(mclk),
        .rst_n(rst_n),
        .cmd(cmd),
        .dec(dec)
    );

    dbsb_bkpt_match #(
        .AW(dbsb_pkg::ADDR_W)
    ) u_match (
        .mclk(mclk),
        .rst_n(rst_n),
        .breakpoint_enable_bit(breakpoint_enable_bit_r),
        .force_tag_select(fts_r),
        .bkptAddr(bkpt_r),
        .cpuBus(cpuBus),
        .instrBoundary(instrBoundary),
        .tagExec(tagExec),
        .tagOut(tagOut),
        .haltHit(haltHit)
    );

    assign wrAddr = cmd.data[dbsb_pkg::ADDR_W-1:0];
    assign debugActive = (mode_r == dbsb_pkg::MODE_HALT); // [RULE_04]
    assign haltReq = debugActive;
    // Halt entered from wait/stop keeps the flag up until resume
    assign wsFlag = cpuWaitStop || wsHalt_r; // [RULE_08]
    assign wsfFlag = wsf_r;

    always_comb begin
        statusByte = dbsb_pkg::STATUS_ZERO; // [RULE_19]
        statusByte[dbsb_pkg::BIT_ENABLE] = enable_r;
        statusByte[dbsb_pkg::BIT_ACTIVE] = debugActive; // [RULE_04]
        statusByte[dbsb_pkg::BIT_BKPT_EN] = breakpoint_enable_bit_r;
        statusByte[dbsb_pkg::BIT_FTS] = fts_r;
        statusByte[dbsb_pkg::BIT_WS] = wsFlag; // [RULE_08]
        statusByte[dbsb_pkg::BIT_WSF] = wsf_r; // [RULE_11]
    end

    always_comb begin
        enable_nxt = enable_r;
        breakpoint_enable_bit_nxt = breakpoint_enable_bit_r;
        fts_nxt = fts_r;
        bkpt_nxt = bkpt_r;
        mode_nxt = mode_r;
        wsHalt_nxt = wsHalt_r;
        wsf_nxt = wsf_r;
        rsp_nxt = '0;
        // Register commands do not depend on mode, except the enable write, which halt ignores: all are non-intrusive
        if (dec.wrControl) begin // [RULE_15]
            // Enable only rises, and not in halt, to avoid forbidding a live halt
            if (!debugActive && cmd.data[dbsb_pkg::BIT_ENABLE]) begin
                enable_nxt = 1'b1; // [RULE_02] [RULE_16]
            end
            breakpoint_enable_bit_nxt = cmd.data[dbsb_pkg::BIT_BKPT_EN];
            fts_nxt = cmd.data[dbsb_pkg::BIT_FTS];
        end
        if (dec.wrBkpt) begin
            bkpt_nxt = wrAddr; // [RULE_13] [RULE_14] [RULE_19]
        end
        if (dec.rdStatus) begin
            rsp_nxt.valid = 1'b1;
            rsp_nxt.data = {8'h00, statusByte}; // [RULE_18]
            wsf_nxt = 1'b0;
        end
        if (dec.rdBkpt) begin
            rsp_nxt.valid = 1'b1;
            rsp_nxt.data = {{(dbsb_pkg::BKPT_W - dbsb_pkg::ADDR_W){1'b0}}, bkpt_r}; // [RULE_13]
        end
        // A failure in the read cycle still lands
        if (memFail) begin
            wsf_nxt = 1'b1; // [RULE_11]
        end
        case (mode_r)
            dbsb_pkg::MODE_RUN: begin
                if (enable_r && (dec.enter || haltHit)) begin // [RULE_01] [RULE_17]
                    mode_nxt = dbsb_pkg::MODE_HALT;
                    wsHalt_nxt = dec.enter && cpuWaitStop; // [RULE_09]
                end
            end
            dbsb_pkg::MODE_HALT: begin
                if (resumeReq) begin
                    mode_nxt = dbsb_pkg::MODE_RUN;
                    wsHalt_nxt = 1'b0;
                end
            end
            default: begin
                mode_nxt = dbsb_pkg::MODE_RUN;
                wsHalt_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= 1'b0;
            breakpoint_enable_bit_r <= 1'b0;
            fts_r <= 1'b0;
            bkpt_r <= dbsb_pkg::BKPT_RESET[dbsb_pkg::ADDR_W-1:0];
            mode_r <= dbsb_pkg::MODE_RUN;
            wsHalt_r <= 1'b0;
            wsf_r <= 1'b0;
            rsp <= '0;
        end else begin
            enable_r <= enable_nxt;
            breakpoint_enable_bit_r <= breakpoint_enable_bit_nxt;
            fts_r <= fts_nxt;
            bkpt_r <= bkpt_nxt;
            mode_r <= mode_nxt;
            wsHalt_r <= wsHalt_nxt;
            wsf_r <= wsf_nxt;
            rsp <= rsp_nxt;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence enterRefused;
        dec.enter && !enable_r && !debugActive;
    endsequence

    sequence wakeEnter;
        dec.enter && enable_r && !debugActive && cpuWaitStop;
    endsequence

    sequence statusRead;
        dec.rdStatus;
    endsequence

    enter_refused_a: assert property (enterRefused |=> !debugActive) // [RULE_01] [RULE_17]
        else $error("halt entered while not enabled");
    enable_sticky_a: assert property (enable_r |=> enable_r) // [RULE_02]
        else $error("enable bit dropped without reset");
    active_flag_a: assert property (statusRead ##0 !memFail |=> // [RULE_04]
        rsp.valid && rsp.data[dbsb_pkg::BIT_ACTIVE] == $past(debugActive))
        else $error("status active bit wrong");
    halt_entry_a: assert property (!debugActive && enable_r && haltHit |=> debugActive && haltReq) // [RULE_06]
        else $error("breakpoint hit did not halt");
    wake_ws_a: assert property (wakeEnter |=> debugActive && wsFlag ##1 (resumeReq || wsFlag)) // [RULE_09]
        else $error("wake from wait/stop not flagged");
    ws_clear_a: assert property (debugActive && resumeReq ##1 !cpuWaitStop |-> !wsFlag) // [RULE_08]
        else $error("wait/stop flag stuck after resume");
    wsf_set_a: assert property (memFail |=> wsfFlag) // [RULE_11]
        else $error("failure flag not set");
    bkpt_read_a: assert property (dec.rdBkpt |=> rsp.valid && rsp.data[15:14] == 2'b00 // [RULE_13]
        && rsp.data[13:0] == $past(bkpt_r))
        else $error("breakpoint read data wrong");
    bkpt_write_a: assert property (dec.wrBkpt |=> bkpt_r == $past(wrAddr)) // [RULE_14]
        else $error("breakpoint write lost");
    ctrl_locked_a: assert property (debugActive && dec.wrControl |=> $stable(enable_r)) // [RULE_16]
        else $error("enable changed in halt");
    status_zero_a: assert property (statusRead |=> rsp.data[15:8] == 8'h00 && !rsp.data[3] // [RULE_19]
        && !rsp.data[0])
        else $error("unimplemented status bit set");

    // Halt is a level the CPU relies on: only a resume may drop it
    sequence haltIdle;
        debugActive && !resumeReq;
    endsequence

    sequence enableWrite;
        dec.wrControl && !debugActive && cmd.data[dbsb_pkg::BIT_ENABLE];
    endsequence

    sequence refusedHit;
        !debugActive && !enable_r && haltHit;
    endsequence

    halt_hold_a: assert property (haltIdle |=> debugActive) // [RULE_04]
        else $error("halt dropped without resume");
    resume_run_a: assert property (debugActive && resumeReq |=> !debugActive) // [RULE_04]
        else $error("resume did not leave halt");
    enable_set_a: assert property (enableWrite |=> enable_r) // [RULE_02]
        else $error("enable write lost");
    hit_refused_a: assert property (refusedHit |=> !debugActive) // [RULE_01]
        else $error("breakpoint halted while not enabled");
    wsf_clear_a: assert property (statusRead ##0 !memFail |=> !wsfFlag) // [RULE_11]
        else $error("failure flag not cleared by status read");
    rsp_idle_a: assert property (!dec.rdStatus && !dec.rdBkpt |=> !rsp.valid) // [RULE_18]
        else $error("reply without a read command");
    cfg_write_a: assert property (dec.wrControl |=> // [RULE_16]
        breakpoint_enable_bit_r == $past(cmd.data[dbsb_pkg::BIT_BKPT_EN]) && fts_r == $past(cmd.data[dbsb_pkg::BIT_FTS]))
        else $error("breakpoint controls not written");
endmodule

// ===== dbsb_host_model.sv
/*
 Debug host model: issues decoded serial commands and collects replies.
 Assumes a one-cycle command pulse and a reply in the cycle after it.
*/
`timescale 1ns/1ps
module dbsb_host_model (
    // Clock
    input wire logic mclk,
    // Command and reply
    output dbsb_pkg::dbsb_cmd_t cmd,
    input wire dbsb_pkg::dbsb_rsp_t rsp
);
    initial cmd = '0;
    // Idle bus shows inverted fields, so stale data never looks valid
    task automatic send(input logic [7:0] code, input logic [15:0] data);
        @(negedge mclk);
        cmd = '{1'b1, code, data};
        @(negedge mclk);
        cmd = '{1'b0, ~code, ~data};
    endtask
    // Reply stands only one cycle, so it is taken right away
    task automatic fetch(input logic [7:0] code, output logic [15:0] d, output logic ok);
        send(code, 16'h0000);
        ok = rsp.valid;
        d = rsp.data;
    endtask
endmodule

// ===== debug_status_and_breakpoint_tb_top.sv
/*
 Testbench for the debug status and breakpoint block.
 Assumes the host model drives commands and the bench drives the CPU taps.
*/
`timescale 1ns/1ps
module debug_status_and_breakpoint_tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic resumeReq = 1'b0;
    logic cpuWaitStop = 1'b0;
    logic memFail = 1'b0;
    logic instrBoundary = 1'b0;
    logic tagExec = 1'b0;
    dbsb_pkg::dbsb_cpu_t cpuBus = '0;
    dbsb_pkg::dbsb_cmd_t cmd;
    dbsb_pkg::dbsb_rsp_t rsp;
    logic haltReq;
    logic debugActive;
    logic tagOut;
    logic wsFlag;
    logic wsfFlag;
    int errCount = 0;
    int checks = 0;
    always #20 mclk = ~mclk;

    dbsb_host_model u_host (.mclk(mclk), .cmd(cmd), .rsp(rsp));
    dbsb_status_bkpt DUT (.mclk(mclk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp),
        .resumeReq(resumeReq), .haltReq(haltReq), .debugActive(debugActive),
        .cpuWaitStop(cpuWaitStop), .memFail(memFail), .instrBoundary(instrBoundary),
        .tagExec(tagExec), .cpuBus(cpuBus), .tagOut(tagOut), .wsFlag(wsFlag),
        .wsfFlag(wsfFlag));

    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic flag(input string n, input logic b, input logic e);
        check(n, {15'h0000, b}, {15'h0000, e});
    endtask
    task automatic expRead(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        u_host.fetch(code, d, ok);
        flag("reply valid", ok, 1'b1);
        check("reply data", d, exp);
    endtask
    task automatic resume();
        resumeReq = 1'b1;
        @(negedge mclk);
        resumeReq = 1'b0;
        flag("resumed", debugActive, 1'b0);
    endtask

    task automatic testRegs();
        expRead(dbsb_pkg::CMD_READ_STATUS, 16'h0000);
        expRead(dbsb_pkg::CMD_BREAKPOINT_READ_COMMAND, 16'h0000);
        u_host.send(dbsb_pkg::CMD_BREAKPOINT_WRITE_COMMAND, 16'hFFFF);
        expRead(dbsb_pkg::CMD_BREAKPOINT_READ_COMMAND, 16'h3FFF);
        u_host.send(dbsb_pkg::CMD_BREAKPOINT_WRITE_COMMAND, 16'h1234);
        expRead(dbsb_pkg::CMD_BREAKPOINT_READ_COMMAND, 16'h1234);
    endtask
    task automatic testEnable();
        u_host.send(dbsb_pkg::CMD_ENTER_DEBUG, 16'h0000);
        flag("halt refused", debugActive, 1'b0);
        u_host.send(dbsb_pkg::CMD_WRITE_CONTROL, 16'h00FF);
        expRead(dbsb_pkg::CMD_READ_STATUS, 16'h00B0);
        u_host.send(dbsb_pkg::CMD_WRITE_CONTROL, 16'h0000);
        expRead(dbsb_pkg::CMD_READ_STATUS, 16'h0080);
    endtask
    task automatic testHalt();
        u_host.send(dbsb_pkg::CMD_ENTER_DEBUG, 16'h0000);
        flag("halt req", haltReq, 1'b1);
        expRead(dbsb_pkg::CMD_READ_STATUS, 16'h00C0);
        u_host.send(dbsb_pkg::CMD_WRITE_CONTROL, 16'h0000);
        expRead(dbsb_pkg::CMD_READ_STATUS, 16'h00C0);
        resume();
        expRead(dbsb_pkg::CMD_READ_STATUS, 16'h0080);
    endtask
    task automatic testWaitStop();
        cpuWaitStop = 1'b1;
        expRead(dbsb_pkg::CMD_READ_STATUS, 16'h0084);
        u_host.send(dbsb_pkg::CMD_ENTER_DEBUG, 16'h0000);
        cpuWaitStop = 1'b0;
        flag("woken", debugActive, 1'b1);
        flag("ws held", wsFlag, 1'b1);
        expRead(dbsb_pkg::CMD_READ_STATUS, 16'h00C4);
        resume();
        expRead(dbsb_pkg::CMD_READ_STATUS, 16'h0080);
    endtask
    task automatic testFail();
        memFail = 1'b1;
        @(negedge mclk);
        memFail = 1'b0;
        flag("wsf", wsfFlag, 1'b1);
        expRead(dbsb_pkg::CMD_READ_STATUS, 16'h0082);
        expRead(dbsb_pkg::CMD_READ_STATUS, 16'h0080);
        u_host.send(dbsb_pkg::CMD_ENTER_DEBUG, 16'h0000);
        resume();
    endtask
    task automatic testBreak();
        u_host.send(dbsb_pkg::CMD_WRITE_CONTROL, 16'h00B0);
        cpuBus = '{1'b1, 1'b0, 14'h1234};
        @(negedge mclk);
        cpuBus = '0;
        flag("no halt yet", debugActive, 1'b0);
        instrBoundary = 1'b1;
        @(negedge mclk);
        instrBoundary = 1'b0;
        flag("force halt", debugActive, 1'b1);
        resume();
        // Breakpoint off: match and boundary together must not halt
        u_host.send(dbsb_pkg::CMD_WRITE_CONTROL, 16'h0090);
        cpuBus = '{1'b1, 1'b1, 14'h1234};
        instrBoundary = 1'b1;
        @(negedge mclk);
        instrBoundary = 1'b0;
        cpuBus = '0;
        flag("bkpt off tag", tagOut, 1'b0);
        @(negedge mclk);
        flag("bkpt off", debugActive, 1'b0);
        u_host.send(dbsb_pkg::CMD_WRITE_CONTROL, 16'h00A0);
        cpuBus = '{1'b1, 1'b1, 14'h1234};
        @(negedge mclk);
        cpuBus = '0;
        flag("tag", tagOut, 1'b1);
        @(negedge mclk);
        flag("tag pulse", tagOut, 1'b0);
        tagExec = 1'b1;
        @(negedge mclk);
        tagExec = 1'b0;
        flag("tag halt", debugActive, 1'b1);
        resume();
    endtask

    task automatic completeRun();
        $display("Checks %0d errors %0d", checks, errCount);
        if (errCount == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        testRegs();
        testEnable();
        testHalt();
        testWaitStop();
        testFail();
        testBreak();
        completeRun();
    end
    // Whole run is near 70 cycles; this span leaves ample margin
    initial begin
        #100000;
        errCount++;
        completeRun();
    end
endmodule
